// ---- rtl/wcp_top.sv ----
module wcp_top
    import wcp_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // two-wire bus, data is open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // logic supply comparators
    input wire logic logic_supply_low,
    input wire logic logic_supply_grounded,
    // regulator set-points
    output logic [3:0] reg2_ref_code,
    output logic [3:0] reg3_ref_code,
    // control outputs
    output logic charger_disable,
    output logic reg1_enable,
    output logic reg2_enable,
    output logic reg3_enable,
    output logic [1:0] reg_mode,
    output logic input_limit_sel_high,
    output logic input_limit_sel_low,
    // command latch update strobe
    output logic cmd_update
);

    logic [NUM_IN-1:0] in_raw;
    logic [NUM_IN-1:0] sync1_r;
    logic [NUM_IN-1:0] sync2_r;
    logic [NUM_IN-1:0] sync3_r;
    logic [NUM_IN-1:0] filt_r;
    logic [NUM_IN-1:0] filt_nxt;
    logic [NUM_IN-1:0] agree;
    logic scl_prev_r;
    logic sda_prev_r;
    logic scl_f;
    logic sda_f;
    logic port_clear;
    logic supply_grounded;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic byte_done;
    logic addr_match;

    wcp_state_t state_r;
    wcp_state_t state_nxt;
    logic [3:0] bit_cnt_r;
    logic [3:0] bit_cnt_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [1:0] idx_r;
    logic [1:0] idx_nxt;
    logic ack_hi_r;
    logic ack_hi_nxt;
    logic oe_r;
    logic oe_nxt;
    logic [7:0] hold_sp_r;
    logic [7:0] hold_sp_nxt;
    logic [7:0] hold_ctl_r;
    logic [7:0] hold_ctl_nxt;
    logic pend_r;
    logic pend_nxt;
    logic commit;
    logic [7:0] cmd_sp_r;
    logic [7:0] cmd_ctl_r;
    logic [7:0] sp_out_r;
    logic [7:0] sp_out_nxt;
    logic [7:0] ctl_out_r;
    logic [7:0] ctl_out_nxt;
    logic upd_r;

    // three-stage sampling; a level is accepted only when stages two and three agree
    assign in_raw = {logic_supply_grounded, logic_supply_low, sda_in, scl_in};
    assign agree = ~(sync2_r ^ sync3_r);
    assign filt_nxt = (agree & sync3_r) | (~agree & filt_r);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_r <= FILT_RESET;
            sync2_r <= FILT_RESET;
            sync3_r <= FILT_RESET;
            filt_r <= FILT_RESET;
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end
        else if (clk_en)
        begin
            sync1_r <= in_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            filt_r <= filt_nxt;
            scl_prev_r <= filt_r[0];
            sda_prev_r <= filt_r[1];
        end
    end

    assign scl_f = filt_r[0];
    assign sda_f = filt_r[1];
    assign port_clear = filt_r[2];
    assign supply_grounded = filt_r[3];

    // edges on filtered lines; at 400 kHz a bus clock phase still spans many core cycles
    assign scl_rise = scl_f & ~scl_prev_r;
    assign scl_fall = ~scl_f & scl_prev_r;
    assign start_det = scl_f & scl_prev_r & sda_prev_r & ~sda_f;
    assign stop_det = scl_f & scl_prev_r & ~sda_prev_r & sda_f;
    assign byte_done = scl_fall && (bit_cnt_r == BYTE_BITS);
    assign addr_match = (shift_r[7:1] == DEV_ADDR) && (shift_r[0] == RW_WRITE);

    always_comb
    begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        idx_nxt = idx_r;
        ack_hi_nxt = ack_hi_r;
        oe_nxt = oe_r;
        hold_sp_nxt = hold_sp_r;
        hold_ctl_nxt = hold_ctl_r;
        pend_nxt = pend_r;
        commit = 1'b0;
        if (port_clear)
        begin
            // lockout wipes the port, including any uncommitted pair
            state_nxt = ST_IDLE;
            oe_nxt = 1'b0;
            pend_nxt = 1'b0;
            bit_cnt_nxt = 4'h0;
            ack_hi_nxt = 1'b0;
        end
        else if (start_det)
        begin
            // a repeated START leaves the held pair untouched
            state_nxt = ST_RX;
            bit_cnt_nxt = 4'h0;
            idx_nxt = IDX_ADDR;
            oe_nxt = 1'b0;
            ack_hi_nxt = 1'b0;
        end
        else if (stop_det)
        begin
            state_nxt = ST_IDLE;
            oe_nxt = 1'b0;
            ack_hi_nxt = 1'b0;
            // partial pair never sets pend, so such a STOP does nothing
            commit = pend_r;
            pend_nxt = 1'b0;
        end
        else
        begin
            case (state_r)
                ST_RX:
                begin
                    if (scl_rise && bit_cnt_r != BYTE_BITS)
                    begin
                        shift_nxt = {shift_r[6:0], sda_f};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end
                    if (byte_done)
                    begin
                        case (idx_r)
                            IDX_ADDR:
                            begin
                                state_nxt = addr_match ? ST_ACK : ST_IGNORE;
                                oe_nxt = addr_match;
                            end
                            IDX_DATA1:
                            begin
                                hold_sp_nxt = shift_r;
                                pend_nxt = 1'b0;
                                state_nxt = ST_ACK;
                                oe_nxt = 1'b1;
                            end
                            IDX_DATA2:
                            begin
                                hold_ctl_nxt = shift_r;
                                pend_nxt = 1'b1;
                                state_nxt = ST_ACK;
                                oe_nxt = 1'b1;
                            end
                            default:
                            begin
                                // a third data byte is refused
                                state_nxt = ST_IGNORE;
                                oe_nxt = 1'b0;
                            end
                        endcase
                    end
                end
                ST_ACK:
                begin
                    // hold low until the acknowledge clock has risen and fallen again
                    if (scl_rise)
                    begin
                        ack_hi_nxt = 1'b1;
                    end
                    if (scl_fall && ack_hi_r)
                    begin
                        oe_nxt = 1'b0;
                        ack_hi_nxt = 1'b0;
                        bit_cnt_nxt = 4'h0;
                        idx_nxt = idx_r + 2'h1;
                        state_nxt = ST_RX;
                    end
                end
                ST_IGNORE:
                begin
                    oe_nxt = 1'b0;
                end
                ST_IDLE:
                begin
                    oe_nxt = 1'b0;
                end
                default:
                begin
                    state_nxt = ST_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            idx_r <= IDX_ADDR;
            ack_hi_r <= 1'b0;
            oe_r <= 1'b0;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            idx_r <= idx_nxt;
            ack_hi_r <= ack_hi_nxt;
            oe_r <= oe_nxt;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            hold_sp_r <= SP_RESET;
            hold_ctl_r <= CTL_RESET;
            pend_r <= 1'b0;
        end
        else if (clk_en)
        begin
            hold_sp_r <= hold_sp_nxt;
            hold_ctl_r <= hold_ctl_nxt;
            pend_r <= pend_nxt;
        end
    end

    // command latch: loads only on a qualifying STOP, cleared by lockout
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cmd_sp_r <= SP_RESET;
            cmd_ctl_r <= CTL_RESET;
            upd_r <= 1'b0;
        end
        else if (clk_en)
        begin
            upd_r <= commit;
            if (port_clear)
            begin
                cmd_sp_r <= SP_RESET;
                cmd_ctl_r <= CTL_RESET;
            end
            else if (commit)
            begin
                cmd_sp_r <= hold_sp_r;
                cmd_ctl_r <= hold_ctl_r;
            end
        end
    end

    // output staging: lockout forces full scale, a grounded supply hands mode to the pins
    assign sp_out_nxt = port_clear ? {FULL_SCALE_CODE, FULL_SCALE_CODE} : cmd_sp_r;
    always_comb
    begin
        ctl_out_nxt = cmd_ctl_r;
        if (supply_grounded)
        begin
            ctl_out_nxt[CTL_MODE_HI] = sda_f;
            ctl_out_nxt[CTL_MODE_LO] = scl_f;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sp_out_r <= SP_RESET;
            ctl_out_r <= CTL_RESET;
        end
        else if (clk_en)
        begin
            sp_out_r <= sp_out_nxt;
            ctl_out_r <= ctl_out_nxt;
        end
    end

    // pad only ever pulls low; release is by the enable
    assign sda_out = 1'b0;
    assign sda_oe = oe_r;

    assign reg2_ref_code = sp_out_r[SP_REG2_HI:SP_REG2_LO];
    assign reg3_ref_code = sp_out_r[SP_REG3_HI:SP_REG3_LO];
    assign charger_disable = ctl_out_r[CTL_CHG_DIS];
    assign reg1_enable = ctl_out_r[CTL_EN1];
    assign reg2_enable = ctl_out_r[CTL_EN2];
    assign reg3_enable = ctl_out_r[CTL_EN3];
    assign reg_mode = ctl_out_r[CTL_MODE_HI:CTL_MODE_LO];
    assign input_limit_sel_high = ctl_out_r[CTL_ILIM_HI];
    assign input_limit_sel_low = ctl_out_r[CTL_ILIM_LO];
    assign cmd_update = upd_r;

endmodule

// ---- rtl/wcp_pkg.sv ----
package wcp_pkg;

    // core clock and the fastest bus clock the port is built for
    localparam int CLK_HZ = 10_000_000;
    localparam int BUS_MAX_HZ = 400_000;
    // shortest bus clock period in core cycles, rounded down
    localparam int BUS_MIN_PERIOD_CYC = CLK_HZ / BUS_MAX_HZ;

    // slave address and the only accepted direction bit
    localparam logic [6:0] DEV_ADDR = 7'h09;
    localparam logic RW_WRITE = 1'b0;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // byte position within an addressed transfer
    localparam logic [1:0] IDX_ADDR = 2'h0;
    localparam logic [1:0] IDX_DATA1 = 2'h1;
    localparam logic [1:0] IDX_DATA2 = 2'h2;

    // command latch values after reset or lockout
    localparam logic [7:0] SP_RESET = 8'hff;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [3:0] FULL_SCALE_CODE = 4'hf;

    // set-point byte fields
    localparam int SP_REG2_HI = 7;
    localparam int SP_REG2_LO = 4;
    localparam int SP_REG3_HI = 3;
    localparam int SP_REG3_LO = 0;

    // control byte fields
    localparam int CTL_CHG_DIS = 7;
    localparam int CTL_MODE_HI = 6;
    localparam int CTL_MODE_LO = 5;
    localparam int CTL_EN1 = 4;
    localparam int CTL_EN2 = 3;
    localparam int CTL_EN3 = 2;
    localparam int CTL_ILIM_HI = 1;
    localparam int CTL_ILIM_LO = 0;

    // input filter bank: bit 0 bus clock, 1 bus data, 2 supply low, 3 supply grounded
    localparam int NUM_IN = 4;
    localparam logic [3:0] FILT_RESET = 4'h3;

    typedef enum logic [1:0]
    {
        MODE_PULSE_SKIP = 2'h0,
        MODE_FORCED_BURST = 2'h1,
        MODE_LDO = 2'h2,
        MODE_AUTO_BURST = 2'h3
    } wcp_mode_t;

    typedef enum logic [1:0]
    {
        ILIM_100MA = 2'h0,
        ILIM_WALL_1A = 2'h1,
        ILIM_SUSPEND = 2'h2,
        ILIM_500MA = 2'h3
    } wcp_ilim_t;

    // gray order along idle -> receive -> acknowledge
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_RX = 2'h1,
        ST_ACK = 2'h3,
        ST_IGNORE = 2'h2
    } wcp_state_t;

endpackage

// ---- tb/wcp_props.sv ----
module wcp_props
    import wcp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // supply
    input wire logic logic_supply_low,
    input wire logic logic_supply_grounded,
    // command outputs
    input wire logic [3:0] reg2_ref_code,
    input wire logic [3:0] reg3_ref_code,
    input wire logic charger_disable,
    input wire logic reg1_enable,
    input wire logic reg2_enable,
    input wire logic reg3_enable,
    input wire logic [1:0] reg_mode,
    input wire logic input_limit_sel_high,
    input wire logic input_limit_sel_low,
    input wire logic cmd_update
);
    timeunit 1ns;
    timeprecision 1ns;

    // a frozen core holds its outputs, so only a_ack_held and a_out_by_upd, which set their own disable, are judged while the enable is low
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset || !clk_en);

    property p_ack_in_low;
        $rose(sda_oe) |-> !scl_in;
    endproperty
    a_ack_in_low: assert property (p_ack_in_low)
        else $error("acknowledge raised while bus clock high");

    // lockout may drop the acknowledge at any point
    property p_ack_held;
        disable iff (reset || logic_supply_low) sda_oe && scl_in |=> sda_oe;
    endproperty
    a_ack_held: assert property (p_ack_held)
        else $error("acknowledge released during clock high");

    property p_open_drain;
        sda_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("data pin driven high");

    property p_upd_pulse;
        cmd_update |=> !cmd_update;
    endproperty
    a_upd_pulse: assert property (p_upd_pulse)
        else $error("update strobe longer than one cycle");

    property p_upd_idle;
        cmd_update |-> scl_in && sda_in;
    endproperty
    a_upd_idle: assert property (p_upd_idle)
        else $error("command latch loaded outside a stop");

    property p_out_by_upd;
        disable iff (reset || logic_supply_low)
        $changed({reg2_ref_code, reg3_ref_code, charger_disable, reg1_enable, reg2_enable,
            reg3_enable, input_limit_sel_high, input_limit_sel_low}) |-> $past(cmd_update);
    endproperty
    a_out_by_upd: assert property (p_out_by_upd)
        else $error("outputs changed without a commit");

    property p_lock_refs;
        logic_supply_low [*6] |-> reg2_ref_code == FULL_SCALE_CODE
            && reg3_ref_code == FULL_SCALE_CODE;
    endproperty
    a_lock_refs: assert property (p_lock_refs)
        else $error("references not full scale in lockout");

    property p_lock_idle;
        logic_supply_low [*6] |-> !sda_oe && !cmd_update;
    endproperty
    a_lock_idle: assert property (p_lock_idle)
        else $error("port active in lockout");

    property p_gnd_mode;
        (logic_supply_grounded && $stable({sda_in, scl_in})) [*8]
            |-> reg_mode == {sda_in, scl_in};
    endproperty
    a_gnd_mode: assert property (p_gnd_mode)
        else $error("mode not taken from pins");
endmodule

bind wcp_top wcp_props wcp_props_inst (.clk, .reset, .clk_en, .scl_in, .sda_in, .sda_out,
    .sda_oe, .logic_supply_low, .logic_supply_grounded, .reg2_ref_code, .reg3_ref_code,
    .charger_disable, .reg1_enable, .reg2_enable, .reg3_enable, .reg_mode,
    .input_limit_sel_high, .input_limit_sel_low, .cmd_update);

// ---- tb/wcp_master.sv ----
module wcp_master
(
    // phases are paced by the core clock
    input wire logic clk,
    // bus clock and data, data released means high
    output logic scl,
    output logic sda_rel,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    task automatic hp(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic pins(input logic c, input logic d);
        scl <= c;
        sda_rel <= d;
    endtask

    // also serves as repeated start from clock low
    task automatic start();
        sda_rel <= 1'b1;
        hp(8);
        scl <= 1'b1;
        hp(8);
        sda_rel <= 1'b0;
        hp(8);
        scl <= 1'b0;
        hp(8);
    endtask

    task automatic stop();
        sda_rel <= 1'b0;
        hp(8);
        scl <= 1'b1;
        hp(8);
        sda_rel <= 1'b1;
        hp(12);
    endtask

    // one-cycle data spike with the clock high; unfiltered it would look like STOP then START
    task automatic spike();
        sda_rel <= 1'b0;
        hp(8);
        scl <= 1'b1;
        hp(8);
        sda_rel <= 1'b1;
        hp(1);
        sda_rel <= 1'b0;
        hp(8);
    endtask

    // 16 low + 12 high core cycles keeps the bus under 400 kHz
    task automatic bit_io(input logic b, output logic s);
        sda_rel <= b;
        hp(8);
        scl <= 1'b1;
        hp(6);
        s = sda;
        hp(6);
        scl <= 1'b0;
        hp(8);
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
endmodule

// ---- tb/wcp_top_tb.sv ----
module wcp_top_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic supply_low = 1'b0;
    logic grounded = 1'b0;
    logic clk_en = 1'b1;
    logic scl, sda_rel, sda_out, sda_oe, cmd_update;
    logic chg, en1, en2, en3, ilh, ill;
    logic [3:0] r2, r3;
    logic [1:0] mode;
    logic [15:0] cur = 16'hff00;
    wire logic sda;
    wire logic [15:0] seen;
    int err_total = 0;
    int comparisons = 0;
    int upd_cnt = 0;
    int exp_upd = 0;
    int cyc = 0;

    // pull-up: wire low only while someone pulls it
    assign sda = sda_rel & ~(sda_oe & ~sda_out);
    assign seen = {r2, r3, chg, mode, en1, en2, en3, ilh, ill};

    wcp_master wcp_master_inst (.clk(clk), .scl(scl), .sda_rel(sda_rel), .sda(sda));

    wcp_top wcp_top_inst (.clk(clk), .reset(reset), .clk_en(clk_en), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .logic_supply_low(supply_low),
        .logic_supply_grounded(grounded), .reg2_ref_code(r2), .reg3_ref_code(r3),
        .charger_disable(chg), .reg1_enable(en1), .reg2_enable(en2), .reg3_enable(en3),
        .reg_mode(mode), .input_limit_sel_high(ilh), .input_limit_sel_low(ill),
        .cmd_update(cmd_update));

    always #50 clk = ~clk;

    always @(posedge clk)
    begin
        cyc++;
        if (cmd_update === 1'b1)
            upd_cnt++;
        if (cyc == 40000)
        begin
            err_total++;
            $display("FAIL timeout exp done got hang");
            summarize();
        end
    end

    task automatic summarize();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic xfer(input logic [7:0] a, sp, ctl, input logic [2:0] ea);
        logic [2:0] k;
        wcp_master_inst.start();
        wcp_master_inst.send(a, k[2]);
        wcp_master_inst.send(sp, k[1]);
        wcp_master_inst.send(ctl, k[0]);
        chk("acks", {13'h0, ea}, {13'h0, k});
    endtask

    // address plus first data byte only
    task automatic part(input logic [7:0] sp);
        logic [1:0] k;
        wcp_master_inst.start();
        wcp_master_inst.send(8'h12, k[1]);
        wcp_master_inst.send(sp, k[0]);
        chk("part acks", 16'h3, {14'h0, k});
    endtask

    task automatic fin(input logic [15:0] e, input int inc);
        wcp_master_inst.stop();
        repeat (4) @(posedge clk);
        exp_upd += inc;
        cur = e;
        chk("command word", e, seen);
        chk("updates", 16'(exp_upd), 16'(upd_cnt));
    endtask

    task automatic t_codes();
        logic [7:0] sp;
        logic [7:0] ctl;
        for (int i = 0; i < 4; i++)
        begin
            sp = {4'(i * 5), 4'(15 - i * 5)};
            ctl = {i[0], i[1:0], (i[0] ? 3'b010 : 3'b101), i[1:0]};
            xfer(8'h12, sp, ctl, 3'b111);
            fin({sp, ctl}, 1);
        end
        $display("codes done");
    endtask

    task automatic t_refuse();
        xfer(8'h13, 8'h00, 8'h00, 3'b000);
        fin(cur, 0);
        xfer(8'h22, 8'h00, 8'h00, 3'b000);
        fin(cur, 0);
        $display("refuse done");
    endtask

    task automatic t_early();
        part(8'h11);
        fin(cur, 0);
        xfer(8'h12, 8'h34, 8'h56, 3'b111);
        fin(16'h3456, 1);
        $display("early stop done");
    endtask

    task automatic t_repeat();
        xfer(8'h12, 8'h77, 8'h88, 3'b111);
        xfer(8'h40, 8'h01, 8'h02, 3'b000);
        xfer(8'h13, 8'h01, 8'h02, 3'b000);
        wcp_master_inst.spike();
        repeat (4) @(posedge clk);
        chk("spike word", cur, seen);
        chk("spike updates", 16'(exp_upd), 16'(upd_cnt));
        fin(16'h7788, 1);
        $display("repeat start done");
    endtask

    task automatic t_readdr();
        xfer(8'h12, 8'h99, 8'haa, 3'b111);
        part(8'h3c);
        fin(cur, 0);
        xfer(8'h12, 8'h3c, 8'hc3, 3'b111);
        fin(16'h3cc3, 1);
        $display("readdress done");
    endtask

    task automatic t_gnd();
        grounded <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            wcp_master_inst.pins(i[0], i[1]);
            repeat (12) @(posedge clk);
            chk("pin mode", 16'(i), {14'h0, mode});
        end
        // with the enable low the pin change must not reach the mode bits
        clk_en <= 1'b0;
        wcp_master_inst.pins(1'b0, 1'b0);
        repeat (12) @(posedge clk);
        chk("frozen mode", 16'h3, {14'h0, mode});
        clk_en <= 1'b1;
        repeat (12) @(posedge clk);
        chk("thawed mode", 16'h0, {14'h0, mode});
        wcp_master_inst.pins(1'b1, 1'b1);
        grounded <= 1'b0;
        repeat (12) @(posedge clk);
        $display("grounded done");
    endtask

    task automatic t_lock();
        supply_low <= 1'b1;
        repeat (10) @(posedge clk);
        chk("lockout word", 16'hff00, seen);
        xfer(8'h12, 8'h5a, 8'h5a, 3'b000);
        supply_low <= 1'b0;
        repeat (10) @(posedge clk);
        fin(16'hff00, 0);
        $display("lockout done");
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (8) @(posedge clk);
        chk("reset word", 16'hff00, seen);
        t_codes();
        t_refuse();
        t_early();
        t_repeat();
        t_readdr();
        t_gnd();
        t_lock();
        summarize();
    end
endmodule
